// ---- parallel_port_dma_pointer_regs_bench.sv ----
`timescale 1ns/1ps
module parallel_port_dma_pointer_regs_bench;
    import ppdma_pkg::*;

    logic mclk, rst_b, bus_init, bus_wr, bus_rd, bus_byte, bus_ack;
    logic [4:0] bus_addr;
    logic [15:0] bus_wdata, bus_rdata, dma_wdata, dma_rdata, usr_din, usr_dout, rd_val;
    logic dma_req, dma_write, dma_ack, usr_req_a, usr_req_b, ndr, ndr_hi, ndr_lo, data_taken;
    logic [17:0] dma_addr;
    logic [1:0] lag;
    int fails, total_checks;
    wire [3:0] strobes = {ndr, ndr_hi, ndr_lo, data_taken};

    ppdma_regs DUT (.mclk(mclk), .rst_b(rst_b), .bus_init(bus_init), .bus_addr(bus_addr), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_byte(bus_byte), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
        .dma_req(dma_req), .dma_write(dma_write), .dma_addr(dma_addr), .dma_wdata(dma_wdata),
        .dma_ack(dma_ack), .dma_rdata(dma_rdata), .usr_din(usr_din), .usr_req_a(usr_req_a),
        .usr_req_b(usr_req_b), .usr_dout(usr_dout), .ndr(ndr), .ndr_hi(ndr_hi), .ndr_lo(ndr_lo),
        .data_taken(data_taken));

    ppdma_mem_model mem (.mclk(mclk), .rst_b(rst_b), .lag(lag), .dma_req(dma_req), .dma_write(dma_write),
        .dma_addr(dma_addr), .dma_wdata(dma_wdata), .dma_ack(dma_ack), .dma_rdata(dma_rdata));

    // ==========================================================
    // Clock and watchdog
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    initial begin
        #3_000_000;
        fails++;
        results();
    end

    // ==========================================================
    // Shared tasks
    task automatic check(input logic [17:0] seen, input logic [17:0] expected);
        total_checks++;
        if (seen !== expected) begin
            fails++;
            $display("wrong value at %0t ns: seen %h expected %h", $time, seen, expected);
        end
    endtask

    // Plain single moves only, no read-modify-write
    task automatic bus_write(input logic [4:0] addr, input logic [15:0] data, input logic is_byte);
        @(posedge mclk);
        #10;
        bus_addr = addr;
        bus_wdata = data;
        bus_byte = is_byte;
        bus_wr = 1'b1;
        @(posedge mclk);
        #10;
        bus_wr = 1'b0;
        bus_byte = 1'b0;
    endtask

    task automatic bus_read(input logic [4:0] addr, output logic [15:0] data);
        @(posedge mclk);
        #10;
        bus_addr = addr;
        bus_rd = 1'b1;
        @(posedge mclk);
        #10;
        bus_rd = 1'b0;
        check(18'(bus_ack), 18'h1);
        data = bus_rdata;
    endtask

    task automatic ind_write(input logic [1:0] sel, input logic [15:0] data, input logic is_byte);
        bus_write(OFF_CTL, {11'h000, sel, 3'h0}, 1'b0);
        bus_write(is_byte ? 5'h1f : OFF_IND, data, is_byte);
    endtask

    task automatic ind_check(input logic [1:0] sel, input logic [15:0] expected);
        bus_write(OFF_CTL, {11'h000, sel, 3'h0}, 1'b0);
        bus_read(OFF_IND, rd_val);
        check(18'(rd_val), 18'(expected));
    endtask

    // One microsecond at 100 ns per cycle is ten cycles
    task automatic pulse_chk(input logic [3:0] expected);
        int n;
        n = 0;
        while (strobes === 4'h0 && n < 5) begin
            @(posedge mclk);
            #10;
            n++;
        end
        for (int i = 0; i < 10; i++) begin
            check(18'(strobes), 18'(expected));
            @(posedge mclk);
            #10;
        end
        check(18'(strobes), 18'h0);
    endtask

    task automatic ctl_bit(input int pos, input logic expected);
        bus_read(OFF_CTL, rd_val);
        check(18'(rd_val[pos]), 18'(expected));
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_indirect();
        logic [15:0] vals [4] = '{16'h1234, 16'hfffe, 16'h8001, 16'h00ff};
        for (int i = 0; i < 4; i++) ind_write(2'(i), vals[i], i == 1);
        for (int i = 0; i < 4; i++) ind_check(2'(i), vals[i]);
        bus_init = 1'b1;
        @(posedge mclk);
        #10;
        bus_init = 1'b0;
        for (int i = 0; i < 4; i++) ind_check(2'(i), 16'h0000);
    endtask

    task automatic t_legacy();
        usr_din = 16'hc3a5;
        bus_read(OFF_IN, rd_val);
        check(18'(rd_val), 18'h0c3a5);
        pulse_chk(4'b0001);
        bus_write(5'h1b, 16'hab00, 1'b1);
        pulse_chk(4'b1100);
        check(18'(usr_dout[15:8]), 18'h000ab);
        bus_write(OFF_OUT, 16'h5555, 1'b0);
        pulse_chk(4'b1110);
    endtask

    task automatic t_silo();
        bus_write(OFF_CTL, 16'h4000, 1'b0);
        bus_write(OFF_MISC, 16'h0004, 1'b0);
        for (int i = 0; i < 3; i++) bus_write(OFF_OUT, 16'h0a00 + 16'(i), 1'b0);
        ind_check(IND_WC_P, 16'h0003);
        usr_req_b = ~usr_req_b;
        pulse_chk(4'b1110);
        check(18'(usr_dout), 18'h00a00);
        ctl_bit(REQB_BIT, 1'b1);
        ind_check(IND_WC_P, 16'h0002);
    endtask

    task automatic wait_words(input int n);
        int k;
        k = 0;
        while (mem.words < n && k < 300) begin
            @(posedge mclk);
            #10;
            k++;
        end
        check(18'(mem.words), 18'(n));
    endtask

    task automatic t_dma();
        bus_write(OFF_CTL, 16'h4000, 1'b0);
        bus_write(OFF_MISC, 16'h4009, 1'b0);
        lag = 2'h0;
        ind_write(IND_BA_P, 16'h1234, 1'b0);
        ind_write(IND_BA_S, 16'h0100, 1'b0);
        ind_write(IND_WC_P, 16'h0002, 1'b0);
        wait_words(2);
        check(mem.addr_log[0], 18'h02468);
        check(mem.addr_log[1], 18'h0246a);
        check(18'(mem.wr_log[0]), 18'h00000);
        ind_check(IND_WC_P, 16'h0000);
        ctl_bit(DONE_P_BIT, 1'b1);
        ind_write(IND_WC_P, 16'h0000, 1'b0);
        ctl_bit(DONE_P_BIT, 1'b0);
        lag = 2'h3;
        ind_write(IND_WC_S, 16'h0001, 1'b0);
        wait_words(3);
        check(mem.addr_log[2], 18'h20200);
        ctl_bit(DONE_S_BIT, 1'b1);
        ind_write(IND_WC_S, 16'h0000, 1'b0);
        ctl_bit(DONE_S_BIT, 1'b0);
        usr_req_a = ~usr_req_a;
        pulse_chk(4'b1110);
        check(18'(usr_dout), 18'(16'h1234 ^ 16'h5a5a));
    endtask

    task automatic t_rx();
        bus_write(OFF_CTL, 16'h4000, 1'b0);
        bus_write(OFF_MISC, 16'h000b, 1'b0);
        ind_write(IND_BA_P, 16'h0040, 1'b0);
        ind_write(IND_WC_P, 16'h0001, 1'b0);
        usr_din = 16'h6b6b;
        usr_req_a = ~usr_req_a;
        pulse_chk(4'b0001);
        wait_words(4);
        check(mem.addr_log[3], 18'h00080);
        check(18'(mem.wr_log[3]), 18'h06b6b);
        bus_read(OFF_IN, rd_val);
        check(18'(rd_val), 18'h06b6b);
    endtask

    // ==========================================================
    // Verdict
    task automatic results();
        $display("checks made %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        fails = 0;
        total_checks = 0;
        rst_b = 1'b0;
        bus_init = 1'b0;
        bus_addr = 5'h00;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_byte = 1'b0;
        bus_wdata = 16'h0000;
        usr_din = 16'h0000;
        usr_req_a = 1'b0;
        usr_req_b = 1'b0;
        lag = 2'h1;
        repeat (10) @(posedge mclk);
        #10;
        rst_b = 1'b1;
        for (int i = 0; i < 4; i++) ind_check(2'(i), 16'h0000);
        t_indirect();
        t_legacy();
        t_silo();
        t_dma();
        t_rx();
        results();
    end
endmodule

// ---- ppdma_fifo.sv ----
`timescale 1ns/1ps
module ppdma_fifo import ppdma_pkg::*; #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Both FIFO sides
    ppdma_fifo_if.fifo f
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } ppdma_fifo_s;

    ppdma_fifo_s st_q;
    ppdma_fifo_s st_d;
    logic push;
    logic pop;

    assign f.in_ready = st_q.cnt != FULL_CNT;
    assign f.out_valid = st_q.cnt != '0;
    assign f.out_data = st_q.mem[st_q.rp];
    assign f.level = st_q.cnt;
    assign push = f.in_valid && f.in_ready;
    assign pop = f.out_valid && f.out_ready;

    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.mem[st_q.wp] = f.in_data;
            st_d.wp = st_q.wp + 1'b1;
        end
        if (pop) begin
            st_d.rp = st_q.rp + 1'b1;
        end
        if (push && !pop) begin
            st_d.cnt = st_q.cnt + 1'b1;
        end else if (pop && !push) begin
            st_d.cnt = st_q.cnt - 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // Checks
    fifo_no_over_a: assert property (@(posedge mclk) disable iff (!rst_b)
        push && !pop |=> st_q.cnt == $past(st_q.cnt) + 1'b1 && st_q.cnt <= FULL_CNT)
        else $error("fifo count wrong after push");
endmodule

// ---- ppdma_fifo_if.sv ----
`timescale 1ns/1ps
interface ppdma_fifo_if #(parameter int W = 16, parameter int AW = 5);
    logic [W-1:0] in_data;
    logic in_valid;
    logic in_ready;
    logic [W-1:0] out_data;
    logic out_valid;
    logic out_ready;
    logic [AW:0] level;
    modport fifo(input in_data, in_valid, out_ready, output in_ready, out_data, out_valid, level);
    modport user(output in_data, in_valid, out_ready, input in_ready, out_data, out_valid, level);
endinterface

// ---- ppdma_mem_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// Host memory as seen from the DMA master port
module ppdma_mem_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Answer delay in cycles
    input wire logic [1:0] lag,
    // DMA slave side
    input wire logic dma_req,
    input wire logic dma_write,
    input wire logic [17:0] dma_addr,
    input wire logic [15:0] dma_wdata,
    output logic dma_ack,
    output logic [15:0] dma_rdata
);
    logic [17:0] addr_log [0:7];
    logic [15:0] wr_log [0:7];
    logic [1:0] wait_q;
    logic [15:0] data_q;
    int words;

    // Data lines carry junk outside the acknowledged cycle
    assign dma_rdata = dma_ack ? data_q : ~data_q;

    always @(posedge mclk) begin
        if (!rst_b) begin
            dma_ack <= 1'b0;
            wait_q <= 2'h0;
            data_q <= 16'h0000;
            words <= 0;
        end else begin
            dma_ack <= 1'b0;
            if (dma_req && !dma_ack) begin
                if (wait_q == lag) begin
                    dma_ack <= 1'b1;
                    data_q <= dma_addr[16:1] ^ 16'h5a5a;
                    addr_log[words[2:0]] <= dma_addr;
                    wr_log[words[2:0]] <= dma_write ? dma_wdata : 16'h0000;
                    words <= words + 1;
                    wait_q <= 2'h0;
                end else begin
                    wait_q <= wait_q + 2'h1;
                end
            end
        end
    end
endmodule

// ---- ppdma_pkg.sv ----
package ppdma_pkg;

    // ==========================================================
    // Register window offsets (byte addresses, word access)
    localparam logic [4:0] OFF_CTL = 5'h18;
    localparam logic [4:0] OFF_OUT = 5'h1a;
    localparam logic [4:0] OFF_IN = 5'h1c;
    localparam logic [4:0] OFF_MISC = 5'h1c;
    localparam logic [4:0] OFF_IND = 5'h1e;

    // ==========================================================
    // Field positions
    localparam int SEL_LO = 3;
    localparam int SEL_HI = 4;
    localparam int DONE_P_BIT = 8;
    localparam int DONE_S_BIT = 9;
    localparam int MRST_BIT = 14;
    localparam int REQB_BIT = 15;
    localparam int MODE_LO = 0;
    localparam int MODE_HI = 3;
    localparam int MSB_S_BIT = 14;
    localparam int MSB_P_BIT = 15;
    localparam int MODE_RX_BIT = 1;
    localparam int MODE_REQA_BIT = 0;

    // ==========================================================
    // Modes and indirect selectors
    localparam logic [3:0] MODE_LEGACY = 4'h0;
    localparam logic [1:0] MCLS_SILO = 2'h1;
    localparam logic [1:0] MCLS_DMA = 2'h2;
    localparam logic [1:0] IND_BA_P = 2'h0;
    localparam logic [1:0] IND_WC_P = 2'h1;
    localparam logic [1:0] IND_BA_S = 2'h2;
    localparam logic [1:0] IND_WC_S = 2'h3;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [15:0] WORD_ONE = 16'h0001;

    // ==========================================================
    // Timing and sizes
    localparam int CLK_NS = 100;
    localparam int PULSE_NS = 1000;
    localparam int PULSE_CYC = (PULSE_NS / CLK_NS < 1) ? 1 : PULSE_NS / CLK_NS;
    localparam int PULSE_W = 4;
    localparam logic [PULSE_W-1:0] PULSE_CNT = PULSE_W'(PULSE_CYC);
    localparam int DATA_W = 16;
    localparam int FIFO_DEPTH = 32;

    typedef enum logic [1:0] {
        DMA_IDLE = 2'b01,
        DMA_BUS = 2'b10
    } ppdma_dma_e;

endpackage

// ---- ppdma_pulse.sv ----
`timescale 1ns/1ps
module ppdma_pulse import ppdma_pkg::*; #(parameter int N = 4) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Triggers and strobes
    input wire logic [N-1:0] trig,
    output logic [N-1:0] pulse
);
    typedef struct packed {
        logic [N-1:0][PULSE_W-1:0] cnt;
        logic [N-1:0][PULSE_W-1:0] run;
    } ppdma_pulse_s;

    ppdma_pulse_s st_q;
    ppdma_pulse_s st_d;
    logic [N-1:0][PULSE_W-1:0] nxt;
    logic [N-1:0][PULSE_W-1:0] nxt_run;

    generate
        for (genvar i = 0; i < N; i++) begin : g_lane
            // Retrigger reloads, so a strobe never ends short
            assign nxt[i] = trig[i] ? PULSE_CNT :
                            (st_q.cnt[i] != '0) ? st_q.cnt[i] - 1'b1 : st_q.cnt[i]; // RULE9
            assign pulse[i] = st_q.cnt[i] != '0;
            // Cycles high so far, saturating at the full width
            assign nxt_run[i] = !pulse[i] ? '0 :
                                (st_q.run[i] != PULSE_CNT) ? st_q.run[i] + 1'b1 : st_q.run[i];
            pulse_width_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE9
                $fell(pulse[i]) |-> st_q.run[i] == PULSE_CNT)
                else $error("strobe shorter than one microsecond");
        end
    endgenerate

    always_comb begin
        st_d = st_q;
        st_d.cnt = nxt;
        st_d.run = nxt_run;
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule

// ---- ppdma_regs.sv ----
`timescale 1ns/1ps
// Summary of operation
// RULE1: Primary address register holds bits 16:1; bit 17 is mode register bit 15.
// RULE2: Transfers are word aligned; address bit 0 is always zero.
// RULE3: Secondary address register holds bits 16:1; bit 17 is mode register bit 14.
// RULE4: In DMA mode software loads primary count with buffer length in words.
// RULE5: Any write to primary count clears the primary done flag, control bit 8; a primary completion in the same cycle sets it instead.
// RULE6: Any write to secondary count clears secondary done, control bit 9; a secondary completion in the same cycle sets it instead.
// RULE7: In silo modes primary count reads back the silo occupancy.
// RULE8: Master reset or bus init clears all four indirect registers.
// RULE9: New-word and input-taken strobes are fixed one microsecond high pulses; a retrigger while high reloads the count and stretches the strobe.
// RULE10: Host must not use read-modify-write cycles on port registers.
// RULE11: In legacy mode software leaves undefined control bits clear.
// RULE12: Byte writes act as word writes, except output buffer in legacy mode.
// RULE13: Host issues byte writes only to output buffer in legacy mode.
// RULE14: Window at 0x1E reaches the indirect register chosen by control bits 4:3.
// RULE15: Mode codes select DMA transmit or receive; low bit picks request A or B.
// RULE16: DMA word address is top bit, sixteen register bits and a zero.
module ppdma_regs import ppdma_pkg::*; (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic bus_init,
    // Host register port
    input wire logic [4:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic bus_byte,
    input wire logic [15:0] bus_wdata,
    output logic [15:0] bus_rdata,
    output logic bus_ack,
    // DMA master port
    output logic dma_req,
    output logic dma_write,
    output logic [17:0] dma_addr,
    output logic [15:0] dma_wdata,
    input wire logic dma_ack,
    input wire logic [15:0] dma_rdata,
    // User device
    input wire logic [15:0] usr_din,
    input wire logic usr_req_a,
    input wire logic usr_req_b,
    output logic [15:0] usr_dout,
    output logic ndr,
    output logic ndr_hi,
    output logic ndr_lo,
    output logic data_taken
);
    typedef struct packed {
        ppdma_dma_e fsm;
        logic [1:0] sel;
        logic done_p;
        logic done_s;
        logic use_s;
        logic [3:0] mode;
        logic msb_p;
        logic msb_s;
        logic [15:0] ba_p;
        logic [15:0] wc_p;
        logic [15:0] ba_s;
        logic [15:0] wc_s;
        logic [15:0] dout;
        logic [15:0] din;
        logic [15:0] rdata;
        logic req_prev;
        logic ack;
    } ppdma_top_s;

    ppdma_top_s st_q;
    ppdma_top_s st_d;
    ppdma_fifo_if #(.W(DATA_W), .AW($clog2(FIFO_DEPTH))) ff ();

    logic [3:0] trig;
    logic [3:0] pulse;
    logic is_silo;
    logic is_dma;
    logic is_rx;
    logic req_now;
    logic req_edge;
    logic hit_ctl;
    logic hit_out;
    logic hit_in;
    logic hit_ind;
    logic set_p;
    logic set_s;
    logic mrst;
    logic fifo_rst_b;
    logic [15:0] act_wc;

    // ==========================================================
    // Mode decode and address decode
    assign is_silo = st_q.mode[MODE_HI:MODE_HI-1] == MCLS_SILO;
    assign is_dma = st_q.mode[MODE_HI:MODE_HI-1] == MCLS_DMA; // RULE15
    assign is_rx = st_q.mode[MODE_RX_BIT];
    assign req_now = st_q.mode[MODE_REQA_BIT] ? usr_req_a : usr_req_b; // RULE15
    assign req_edge = req_now != st_q.req_prev;
    // Address bit 0 never takes part in the decode
    assign hit_ctl = bus_addr[4:1] == OFF_CTL[4:1]; // RULE12
    assign hit_out = bus_addr[4:1] == OFF_OUT[4:1];
    assign hit_in = bus_addr[4:1] == OFF_IN[4:1];
    assign hit_ind = bus_addr[4:1] == OFF_IND[4:1]; // RULE14
    assign act_wc = st_q.use_s ? st_q.wc_s : st_q.wc_p;
    assign fifo_rst_b = rst_b && !bus_init && !mrst;

    // ==========================================================
    // Next state
    always_comb begin
        st_d = st_q;
        trig = '0;
        set_p = 1'b0;
        set_s = 1'b0;
        mrst = 1'b0;
        ff.in_valid = 1'b0;
        ff.in_data = WORD_ZERO;
        ff.out_ready = 1'b0;
        st_d.req_prev = req_now;
        st_d.ack = bus_rd || bus_wr;

        // User handshake: each request transition moves one word
        if (req_edge && st_q.mode != MODE_LEGACY) begin
            if (!is_rx && ff.out_valid && !(is_dma && st_q.fsm == DMA_BUS && is_rx)) begin
                ff.out_ready = 1'b1;
                st_d.dout = ff.out_data;
                trig[2:0] = 3'h7; // RULE9
            end else if (is_rx && ff.in_ready) begin
                ff.in_valid = 1'b1;
                ff.in_data = usr_din;
                trig[3] = 1'b1; // RULE9
            end
        end

        // DMA engine
        case (st_q.fsm)
            DMA_IDLE: begin
                if (is_dma && act_wc != WORD_ZERO && (is_rx ? ff.out_valid : ff.in_ready)) begin // RULE4
                    st_d.fsm = DMA_BUS;
                end
            end
            DMA_BUS: begin
                if (dma_ack) begin
                    if (is_rx) begin
                        ff.out_ready = 1'b1;
                        st_d.din = ff.out_data;
                    end else begin
                        ff.in_valid = 1'b1;
                        ff.in_data = dma_rdata;
                    end
                    if (st_q.use_s) begin
                        st_d.wc_s = st_q.wc_s - WORD_ONE;
                        st_d.ba_s = st_q.ba_s + WORD_ONE;
                        set_s = st_q.wc_s == WORD_ONE;
                    end else begin
                        st_d.wc_p = st_q.wc_p - WORD_ONE; // RULE4
                        st_d.ba_p = st_q.ba_p + WORD_ONE;
                        set_p = st_q.wc_p == WORD_ONE;
                    end
                    if (set_p || set_s) begin
                        st_d.use_s = !st_q.use_s;
                    end
                    st_d.fsm = DMA_IDLE;
                end
            end
            default: begin
                st_d.fsm = DMA_IDLE;
            end
        endcase

        // Host writes; byte cycles carry the whole word except legacy output bytes
        if (bus_wr) begin
            if (hit_ctl) begin
                st_d.sel = bus_wdata[SEL_HI:SEL_LO];
                mrst = bus_wdata[MRST_BIT];
            end else if (hit_in) begin
                st_d.mode = bus_wdata[MODE_HI:MODE_LO];
                st_d.msb_p = bus_wdata[MSB_P_BIT]; // RULE1
                st_d.msb_s = bus_wdata[MSB_S_BIT]; // RULE3
            end else if (hit_out) begin
                if (st_q.mode == MODE_LEGACY && bus_byte) begin
                    if (bus_addr[0]) begin
                        st_d.dout[15:8] = bus_wdata[15:8];
                        trig[1:0] = 2'h3;
                    end else begin
                        st_d.dout[7:0] = bus_wdata[7:0];
                        trig[2] = 1'b1;
                        trig[0] = 1'b1;
                    end
                end else if (is_silo && !is_rx) begin
                    ff.in_valid = 1'b1;
                    ff.in_data = bus_wdata;
                end else begin
                    st_d.dout = bus_wdata; // RULE12
                    if (st_q.mode == MODE_LEGACY) begin
                        trig[2:0] = 3'h7; // RULE9
                    end
                end
            end else if (hit_ind) begin
                case (st_q.sel) // RULE14
                    IND_BA_P: st_d.ba_p = bus_wdata; // RULE1
                    IND_WC_P: begin
                        st_d.wc_p = bus_wdata;
                        st_d.done_p = 1'b0; // RULE5
                    end
                    IND_BA_S: st_d.ba_s = bus_wdata; // RULE3
                    IND_WC_S: begin
                        st_d.wc_s = bus_wdata;
                        st_d.done_s = 1'b0; // RULE6
                    end
                    default: st_d.ba_p = st_q.ba_p;
                endcase
            end
        end

        // Completion beats a clear in the same cycle
        if (set_p) begin
            st_d.done_p = 1'b1;
        end
        if (set_s) begin
            st_d.done_s = 1'b1;
        end

        // Host reads
        st_d.rdata = WORD_ZERO;
        if (bus_rd) begin
            if (hit_ctl) begin
                st_d.rdata[SEL_HI:SEL_LO] = st_q.sel;
                st_d.rdata[DONE_P_BIT] = st_q.done_p;
                st_d.rdata[DONE_S_BIT] = st_q.done_s;
                st_d.rdata[REQB_BIT] = usr_req_b;
            end else if (hit_out) begin
                st_d.rdata = st_q.dout;
            end else if (hit_in) begin
                if (is_silo && is_rx) begin
                    st_d.rdata = ff.out_data;
                    ff.out_ready = ff.out_valid;
                end else if (is_dma && is_rx) begin
                    st_d.rdata = st_q.din;
                end else begin
                    st_d.rdata = usr_din;
                    trig[3] = 1'b1; // RULE9
                end
            end else if (hit_ind) begin
                case (st_q.sel) // RULE14
                    IND_BA_P: st_d.rdata = st_q.ba_p;
                    IND_WC_P: st_d.rdata = is_silo ? 16'(ff.level) : st_q.wc_p; // RULE7
                    IND_BA_S: st_d.rdata = st_q.ba_s;
                    IND_WC_S: st_d.rdata = st_q.wc_s;
                    default: st_d.rdata = WORD_ZERO;
                endcase
            end
        end

        if (bus_init || mrst) begin
            st_d = '0; // RULE8
            st_d.fsm = DMA_IDLE;
            st_d.req_prev = req_now;
            st_d.ack = bus_rd || bus_wr;
            trig = '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            st_q <= '0;
            st_q.fsm <= DMA_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // Outputs
    assign bus_rdata = st_q.rdata;
    assign bus_ack = st_q.ack;
    assign dma_req = st_q.fsm == DMA_BUS;
    assign dma_write = is_rx;
    assign dma_addr = st_q.use_s ? {st_q.msb_s, st_q.ba_s, 1'b0} : {st_q.msb_p, st_q.ba_p, 1'b0}; // RULE16
    assign dma_wdata = ff.out_data;
    assign usr_dout = st_q.dout;
    assign ndr = pulse[0];
    assign ndr_hi = pulse[1];
    assign ndr_lo = pulse[2];
    assign data_taken = pulse[3];

    ppdma_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .rst_b(fifo_rst_b),
        .f(ff.fifo)
    );

    ppdma_pulse #(.N(4)) u_pulse (
        .mclk(mclk),
        .rst_b(rst_b),
        .trig(trig),
        .pulse(pulse)
    );

    // ==========================================================
    // Checks
    pri_addr_form_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE1
        dma_req && !st_q.use_s |-> dma_addr == {st_q.msb_p, st_q.ba_p, 1'b0})
        else $error("primary address misformed");
    sec_addr_form_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE3
        dma_req && st_q.use_s |-> dma_addr[17:1] == {st_q.msb_s, st_q.ba_s})
        else $error("secondary address misformed");
    word_align_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE2
        dma_req |-> !dma_addr[0])
        else $error("odd dma address");
    count_step_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE4
        dma_req && dma_ack && !st_q.use_s && !bus_wr && !bus_init |=> st_q.wc_p == $past(st_q.wc_p) - 16'h0001)
        else $error("primary count did not step");
    done_p_clr_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE5
        bus_wr && hit_ind && st_q.sel == IND_WC_P && !set_p |=> !st_q.done_p)
        else $error("primary done not cleared");
    done_s_clr_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE6
        bus_wr && hit_ind && st_q.sel == IND_WC_S && !set_s |=> !st_q.done_s)
        else $error("secondary done not cleared");
    silo_level_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE7
        bus_rd && hit_ind && st_q.sel == IND_WC_P && is_silo && !bus_init |=> bus_rdata == 16'($past(ff.level)))
        else $error("silo occupancy not reported");
    init_clear_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE8
        bus_init |=> st_q.ba_p == 16'h0000 && st_q.wc_p == 16'h0000 && st_q.ba_s == 16'h0000 && st_q.wc_s == 16'h0000)
        else $error("indirect registers not cleared");
    byte_as_word_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE12
        bus_wr && bus_byte && hit_ind && st_q.sel == IND_BA_P && !bus_init |=> st_q.ba_p == $past(bus_wdata))
        else $error("byte write not taken as word");
    window_sel_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE14
        bus_wr && hit_ind && st_q.sel == IND_BA_S && !bus_init |=> st_q.ba_s == $past(bus_wdata) && $stable(st_q.ba_p))
        else $error("indirect window wrong target");
    pace_strobe_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE15
        is_dma && !is_rx && req_edge && ff.out_valid && !bus_init |=> ##1 ndr && usr_dout == $past(ff.out_data, 2))
        else $error("paced word not delivered");
endmodule
